//--- hdl/dac_lut_control_registers.v
`timescale 1ns/1ns
`include "dac_lut_map.vh"
module dac_lut_control_registers #(
    parameter CHANNELS = 4
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        ce,
    input  wire        wr_en,
    input  wire        rd_en,
    input  wire [7:0]  addr,
    input  wire [7:0]  wr_data,
    output reg  [7:0]  rd_data,
    input  wire        temp_done_evt,
    input  wire        supply_busy,
    input  wire [15:0] temp_reading,
    input  wire [15:0] supply_reading,
    input  wire [7:0]  calc_pointer,
    input  wire [7:0]  upper_rd_data,
    input  wire [63:0] lut_codes,
    input  wire [63:0] startup_codes_in,
    output reg  [3:0]  table_select,
    output reg         upper_access,
    output reg  [7:0]  lut_pointer,
    output reg  [7:0]  status_byte,
    output reg  [7:0]  mode_byte,
    output reg  [39:0] channel_levels,
    output wire        nv_write,
    output wire [7:0]  nv_addr,
    output wire [7:0]  nv_data
);
    // ==========================================================
    // storage
    reg  [7:0]  scratch_byte;
    reg  [7:0]  code_mem [0:`ROW_BYTES-1];
    reg  [7:0]  start_mem [0:`ROW_BYTES-1];
    wire        status_wr;
    reg         supply_flag;
    wire [39:0] levels_w;
    integer     i;

    // row/byte decoding used for reads and writes
    function [2:0] row_byte;
        input [7:0] a;
        begin
            row_byte = a[2:0];
        end
    endfunction

    // true for any byte of the output-code row
    function in_code_row;
        input [7:0] a;
        begin
            in_code_row = (a >= `OFS_CODE_BASE) && (a <= `OFS_CODE_LAST);
        end
    endfunction

    // true for any byte of the shadowed startup-code row
    function in_start_row;
        input [7:0] a;
        begin
            in_start_row = (a >= `OFS_START_BASE) && (a <= `OFS_START_LAST);
        end
    endfunction

    // only codes 4..7 name a table; anything else keeps the window shut
    function tsel_usable;
        input [3:0] t;
        begin
            tsel_usable = (t >= `TSEL_BASE) && (t <= `TSEL_LAST);
        end
    endfunction

    // status write strobe, shared by the flag and the field logic
    assign status_wr = wr_en && (addr == `OFS_STATUS);

    // ==========================================================
    // status register: flags, spare bits and table select
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_byte <= `RST_STATUS;
            supply_flag <= 1'b0;
        end else if (ce) begin
            supply_flag <= !supply_busy;
            if (status_wr) begin
                status_byte[5:0] <= wr_data[5:0];
            end
            // hardware set beats a simultaneous clear
            if (temp_done_evt) begin
                status_byte[`BIT_TEMP_DONE] <= 1'b1;
            end else if (status_wr && !wr_data[`BIT_TEMP_DONE]) begin
                status_byte[`BIT_TEMP_DONE] <= 1'b0;
            end
            status_byte[`BIT_SUPPLY_DONE] <= supply_flag;
        end
    end

    // ==========================================================
    // mode and scratch bytes
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_byte    <= `RST_MODE;
            scratch_byte <= `RST_SCRATCH;
        end else if (ce && wr_en) begin
            if (addr == `OFS_MODE) begin
                mode_byte <= wr_data;
            end else if (addr == `OFS_SCRATCH) begin
                scratch_byte <= wr_data;
            end
        end
    end

    // ==========================================================
    // table select decode; only codes 4..7 expose a table
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            table_select <= 4'h0;
            upper_access <= 1'b0;
        end else if (ce) begin
            table_select <= status_byte[`TSEL_MSB:0];
            upper_access <= addr[`UPPER_BIT] && (rd_en || wr_en) &&
                            tsel_usable(status_byte[`TSEL_MSB:0]);
        end
    end

    // ==========================================================
    // lookup pointer: host-written when auto off, calculated when on
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lut_pointer <= `RST_POINTER;
        end else if (ce) begin
            if (mode_byte[`BIT_AUTO_INDEX]) begin
                if (temp_done_evt) begin
                    lut_pointer <= calc_pointer;
                end
            end else if (wr_en && addr == `OFS_POINTER) begin
                lut_pointer <= wr_data;
            end
        end
    end

    // ==========================================================
    // output codes: table results load only at conversion end
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < `ROW_BYTES; i = i + 1) begin
                code_mem[i]  <= 8'h00;
                start_mem[i] <= 8'h00;
            end
        end else if (ce) begin
            if (temp_done_evt) begin
                for (i = 0; i < `ROW_BYTES; i = i + 1) begin
                    code_mem[i] <= lut_codes[i*8 +: 8];
                end
            end else if (wr_en && in_code_row(addr)) begin
                code_mem[row_byte(addr)] <= wr_data;
            end
            if (wr_en && in_start_row(addr)) begin
                start_mem[row_byte(addr)] <= wr_data;
            end
        end
    end

    // ==========================================================
    // read mux; unmapped lower locations return zero
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 8'h00;
        end else if (ce && rd_en) begin
            if (addr[`UPPER_BIT]) begin
                rd_data <= upper_rd_data;
            end else if (addr == `OFS_STATUS) begin
                rd_data <= status_byte;
            end else if (addr == `OFS_MODE) begin
                rd_data <= mode_byte;
            end else if (addr == `OFS_SCRATCH) begin
                rd_data <= scratch_byte;
            end else if (addr == `OFS_POINTER) begin
                rd_data <= lut_pointer;
            end else if (addr == `OFS_TEMP_HI) begin
                rd_data <= temp_reading[15:8];
            end else if (addr == `OFS_TEMP_LO) begin
                rd_data <= temp_reading[7:0];
            end else if (addr == `OFS_SUPPLY_HI) begin
                rd_data <= supply_reading[15:8];
            end else if (addr == `OFS_SUPPLY_LO) begin
                rd_data <= supply_reading[7:0];
            end else if (in_code_row(addr)) begin
                rd_data <= code_mem[row_byte(addr)];
            end else if (in_start_row(addr)) begin
                rd_data <= start_mem[row_byte(addr)];
            end else begin
                rd_data <= 8'h00;
            end
        end
    end

    // ==========================================================
    // channels: channel 3 sits first in the row, channel 0 last
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
            channel_force u_force (
                .clk              (clk),
                .rstn             (rstn),
                .ce               (ce),
                .code             ({code_mem[6-2*g], code_mem[7-2*g][7:6]}),
                .invert           (startup_codes_in[(6-2*g)*8+8+`BIT_INVERT]),
                .force_output_off (mode_byte[`BIT_FORCE_OFF]),
                .level            (levels_w[g*10 +: 10])
            );
        end
    endgenerate

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            channel_levels <= 40'h0000000000;
        end else if (ce) begin
            channel_levels <= levels_w;
        end
    end

    nv_commit_gate u_commit (
        .clk            (clk),
        .rstn           (rstn),
        .ce             (ce),
        .wr_en          (wr_en),
        .wr_addr        (addr),
        .wr_data        (wr_data),
        .shadow_inhibit (mode_byte[`BIT_SHADOW_INH]),
        .nv_write       (nv_write),
        .nv_addr        (nv_addr),
        .nv_data        (nv_data)
    );
endmodule // dac_lut_control_registers

//--- inc/dac_lut_map.vh
// Function
// - control 00h, mode 01h, scratch 02h, words
// - eight bytes per row, byte/word stepping
// - bit7 temp done, bit6 supply done
// - bits 3:0 pick upper table
// - spare bits store and read back only
// - mode resets 40h, others 00h
// - mode bit7 suppresses nonvolatile commit
// - auto index off lets host write pointer
// - manual pointer loads on write, codes at next conversion
// - auto index on: pointer from temperature
// - mode bit0 forces outputs to polarity
// - per channel full scale or zero
// - selected table visible at 80h-FFh
// - polarity bit inverts channel code
// - shadow inhibit makes startup codes volatile
// - pointer writable only with auto off
`ifndef DAC_LUT_MAP_VH
`define DAC_LUT_MAP_VH
// ==========================================================
// register offsets
`define OFS_STATUS      8'h00
`define OFS_MODE        8'h01
`define OFS_SCRATCH     8'h02
`define OFS_POINTER     8'h03
`define OFS_TEMP_HI     8'h04
`define OFS_TEMP_LO     8'h05
`define OFS_SUPPLY_HI   8'h06
`define OFS_SUPPLY_LO   8'h07
`define OFS_CODE_BASE   8'h10
`define OFS_CODE_LAST   8'h17
`define OFS_START_BASE  8'h78
`define OFS_START_LAST  8'h7F
`define UPPER_BIT       7
`define ROW_BYTES       8
// ==========================================================
// field positions
`define BIT_TEMP_DONE   7
`define BIT_SUPPLY_DONE 6
`define BIT_SHADOW_INH  7
`define BIT_AUTO_INDEX  6
`define BIT_FORCE_OFF   0
`define BIT_INVERT      1
`define TSEL_MSB        3
`define TSEL_BASE       4'h4
`define TSEL_LAST       4'h7
// ==========================================================
// reset values
`define RST_STATUS      8'h00
`define RST_MODE        8'h40
`define RST_SCRATCH     8'h00
`define RST_POINTER     8'h00
`define CODE_FULL       10'h3FF
`define CODE_ZERO       10'h000
`endif

//--- hdl/nv_commit_gate.v
`timescale 1ns/1ns
`include "dac_lut_map.vh"
module nv_commit_gate (
    input  wire       clk,
    input  wire       rstn,
    input  wire       ce,
    input  wire       wr_en,
    input  wire [7:0] wr_addr,
    input  wire [7:0] wr_data,
    input  wire       shadow_inhibit,
    output reg        nv_write,
    output reg  [7:0] nv_addr,
    output reg  [7:0] nv_data
);
    // ==========================================================
    // commit logic
    // startup-code bytes go to nonvolatile storage only when not inhibited
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nv_write <= 1'b0;
            nv_addr  <= 8'h00;
            nv_data  <= 8'h00;
        end else if (ce) begin
            nv_write <= wr_en && !shadow_inhibit && (wr_addr >= `OFS_START_BASE) &&
                        (wr_addr <= `OFS_START_LAST);
            nv_addr  <= wr_addr;
            nv_data  <= wr_data;
        end
    end
endmodule // nv_commit_gate

//--- hdl/channel_force.v
`timescale 1ns/1ns
`include "dac_lut_map.vh"
module channel_force (
    input  wire       clk,
    input  wire       rstn,
    input  wire       ce,
    input  wire [9:0] code,
    input  wire       invert,
    input  wire       force_output_off,
    output reg  [9:0] level
);
    // ==========================================================
    // effective level; forced level follows polarity bit alone
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level <= `CODE_ZERO;
        end else if (ce) begin
            if (force_output_off) begin
                level <= invert ? `CODE_FULL : `CODE_ZERO;
            end else begin
                level <= invert ? ~code : code;
            end
        end
    end
endmodule // channel_force

//--- bench/dac_regs_properties.sv
`timescale 1ns/1ns
// ==========================================================
// port checker for the control register bank
module dac_regs_properties #(
    parameter CHANNELS = 4
) (
    input logic        clk,
    input logic        rstn,
    input logic        ce,
    input logic        wr_en,
    input logic        rd_en,
    input logic [7:0]  addr,
    input logic [7:0]  wr_data,
    input logic        temp_done_evt,
    input logic        supply_busy,
    input logic [63:0] startup_codes_in,
    input logic [3:0]  table_select,
    input logic        upper_access,
    input logic [7:0]  status_byte,
    input logic [7:0]  mode_byte,
    input logic [39:0] channel_levels,
    input logic        nv_write,
    input logic [7:0]  nv_addr,
    input logic [7:0]  nv_data
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    // request decodes; the shadowed startup bytes sit at 78h-7Fh
    wire sw  = ce && wr_en && addr[7:3] == 5'h0F;
    wire cw  = ce && wr_en && addr == 8'h00;
    wire acc = ce && (wr_en || rd_en);
    AST_RESET: assert property (disable iff (1'b0) !rstn |-> mode_byte == 8'h40 && status_byte == 8'h00)
        else $error("reset values wrong");
    AST_COMMIT: assert property (sw && !mode_byte[7] |=>
        nv_write && nv_addr == $past(addr) && nv_data == $past(wr_data))
        else $error("startup write not committed");
    AST_TSEL: assert property (cw ##1 ce |=> table_select == $past(wr_data[3:0], 2))
        else $error("table select not taken");
    AST_UPPER: assert property (acc && addr[7] && status_byte[3:2] == 2'b01 |=> upper_access)
        else $error("upper window not opened");
    AST_DONE_SET: assert property (ce && temp_done_evt |=> status_byte[7])
        else $error("temperature done not set");
    AST_DONE_CLR: assert property (cw && !wr_data[7] && !temp_done_evt |=> !status_byte[7])
        else $error("temperature done not cleared");
    AST_SUPPLY: assert property ((ce && !supply_busy)[*3] |-> status_byte[6])
        else $error("supply done missing");
    AST_FORCE: assert property ((ce && mode_byte[0] && $stable(startup_codes_in))[*4] |->
        channel_levels[9:0] == {10{startup_codes_in[57]}})
        else $error("forced level wrong");
    COV_COMMIT: cover property (sw && !mode_byte[7]);
    COV_FORCE: cover property (ce && mode_byte[0]);
    COV_UPPER: cover property (upper_access);
endmodule // dac_regs_properties

bind dac_lut_control_registers dac_regs_properties #(.CHANNELS(CHANNELS)) chk_u (.clk, .rstn, .ce, .wr_en, .rd_en,
    .addr, .wr_data, .temp_done_evt, .supply_busy, .startup_codes_in, .table_select, .upper_access, .status_byte,
    .mode_byte, .channel_levels, .nv_write, .nv_addr, .nv_data);

//--- bench/nv_store_model.sv
`timescale 1ns/1ns
// ==========================================================
// nonvolatile startup store behind the commit port
module nv_store_model #(
    parameter [63:0] INIT = 64'h0
) (
    input  wire        clk,
    input  wire        nv_write,
    input  wire [7:0]  nv_addr,
    input  wire [7:0]  nv_data,
    output reg  [63:0] startup_codes_in
);
    // no reset: committed bytes outlive every reset of the bank
    initial startup_codes_in = INIT;
    // only a commit pulse changes a byte, so inhibited writes never land
    always @(posedge clk) begin
        if (nv_write)
            startup_codes_in[{nv_addr[2:0], 3'b000} +: 8] <= nv_data;
    end
endmodule // nv_store_model

//--- bench/dac_lut_control_registers_tb.sv
`timescale 1ns/1ns
// ==========================================================
// bench: row table first, then reset and corner cases
module dac_lut_control_registers_tb;
    reg         clk, rstn, ce, wr_en, rd_en, temp_done_evt, supply_busy;
    reg  [7:0]  addr, wr_data, calc_pointer, got;
    reg  [63:0] lut_codes;
    reg  [1:0]  sel;
    wire [7:0]  rd_data, lut_pointer, status_byte, mode_byte, nv_addr, nv_data;
    wire [63:0] startup_codes_in;
    wire [39:0] channel_levels;
    wire [3:0]  table_select;
    wire        upper_access, nv_write;
    integer     failures, cmp_count, i;
    // one poll serves the pointer and both end channels
    wire [9:0]  probe = sel[1] ? channel_levels[39:30] : sel[0] ? channel_levels[9:0] : {2'b00, lut_pointer};
    // rows: write flag, address, data, expected readback
    localparam logic [24:0] ROWS [10] = '{25'h1003535, 25'h1013E3E, 25'h102A5A5, 25'h1039C9C, 25'h112C0C0,
        25'h1134040, 25'h0040019, 25'h0050030, 25'h00600BE, 25'h00700E8};
    // free running 50 MHz clock
    always #10 clk = ~clk;
    dac_lut_control_registers dut_u (.clk, .rstn, .ce, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
        .temp_done_evt, .supply_busy, .temp_reading(16'h1930), .supply_reading(16'hBEE8), .calc_pointer,
        .upper_rd_data(8'h5A), .lut_codes, .startup_codes_in, .table_select, .upper_access, .lut_pointer,
        .status_byte, .mode_byte, .channel_levels, .nv_write, .nv_addr, .nv_data);
    nv_store_model #(.INIT(64'h0200_0000_0000_0000)) nv_u (.clk, .nv_write, .nv_addr, .nv_data, .startup_codes_in);
    // ==========================================================
    // shared tasks
    task complete_run;
        begin
            $display("failures %0d compares %0d", failures, cmp_count);
            if (failures == 0 && cmp_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input [9:0] g, input [9:0] e);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("Error at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    // request held over one taking edge, read data sampled after it
    task xfer(input w, input [7:0] a, input [7:0] d);
        begin
            @(posedge clk) #1;
            addr = a;
            wr_data = d;
            wr_en = w;
            rd_en = !w;
            @(posedge clk) #1;
            wr_en = 1'b0;
            rd_en = 1'b0;
            got = rd_data;
        end
    endtask
    task pulse;
        begin
            @(posedge clk) #1;
            temp_done_evt = 1'b1;
            @(posedge clk) #1;
            temp_done_evt = 1'b0;
        end
    endtask
    // bounded wait; running out counts a mismatch and ends the run
    task poll(input [1:0] s, input [9:0] e);
        begin
            sel = s;
            for (i = 0; i < 16 && probe !== e; i = i + 1)
                @(posedge clk) #1;
            chk(probe, e);
            if (probe !== e)
                complete_run;
        end
    endtask
    // ==========================================================
    // stimulus
    initial begin
        {wr_en, rd_en, temp_done_evt, addr, wr_data, calc_pointer, sel} = 0;
        {clk, ce, supply_busy, rstn} = 4'b0111;
        lut_codes = 64'h0;
        failures = 0;
        cmp_count = 0;
        // reset falls after time zero so every register process sees its edge
        #1 rstn = 1'b0;
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        for (i = 0; i < 10; i = i + 1) begin
            if (ROWS[i][24])
                xfer(1'b1, ROWS[i][23:16], ROWS[i][15:8]);
            xfer(1'b0, ROWS[i][23:16], 8'h00);
            chk(got, ROWS[i][7:0]);
        end
        // second reset in mid-run
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            xfer(1'b0, i[7:0], 8'h00);
            chk(got, i == 1 ? 8'h40 : 8'h00);
        end
        // clock enable low: the write must not land
        ce = 1'b0;
        xfer(1'b1, 8'h02, 8'h3C);
        ce = 1'b1;
        xfer(1'b0, 8'h02, 8'h00);
        chk(got, 8'h00);
        // auto index on: host pointer write refused before any conversion
        calc_pointer = 8'h87;
        xfer(1'b1, 8'h03, 8'h11);
        xfer(1'b0, 8'h03, 8'h00);
        chk(got, 8'h00);
        pulse;
        poll(2'd0, 10'h087);
        // auto off: codes load only on the next conversion
        xfer(1'b1, 8'h01, 8'h00);
        xfer(1'b1, 8'h03, 8'hA2);
        lut_codes = 64'hFFFF_0000_0000_C3D5;
        xfer(1'b0, 8'h10, 8'h00);
        chk(got, 8'h00);
        pulse;
        xfer(1'b0, 8'h10, 8'h00);
        chk(got, 8'hD5);
        xfer(1'b0, 8'h03, 8'h00);
        chk(got, 8'hA2);
        poll(2'd2, 10'h357);
        poll(2'd1, 10'h000);
        xfer(1'b1, 8'h01, 8'h01);
        poll(2'd1, 10'h3FF);
        poll(2'd2, 10'h000);
        // done flags, then the upper window with table 4
        supply_busy = 1'b0;
        xfer(1'b0, 8'h00, 8'h00);
        chk(got & 8'h80, 8'h80);
        xfer(1'b1, 8'h00, 8'h04);
        xfer(1'b0, 8'h00, 8'h00);
        chk(got, 8'h44);
        xfer(1'b0, 8'h80, 8'h00);
        chk(got, 8'h5A);
        // inhibit keeps the stored byte but the volatile copy takes the write
        xfer(1'b1, 8'h01, 8'h80);
        xfer(1'b1, 8'h7F, 8'h5C);
        repeat (2) @(posedge clk) #1;
        chk(startup_codes_in[63:56], 8'h02);
        xfer(1'b0, 8'h7F, 8'h00);
        chk(got, 8'h5C);
        // clear the inhibit and rewrite so the value is committed
        xfer(1'b1, 8'h01, 8'h00);
        xfer(1'b1, 8'h7F, 8'h00);
        repeat (2) @(posedge clk) #1;
        chk(startup_codes_in[63:56], 8'h00);
        complete_run;
    end
endmodule // dac_lut_control_registers_tb
